// File: rtl/sctt_timer.sv
// slow tick timer: 23-bit trimmed counter on the slow clock, tick flag, count registers
// assumes a one-cycle sfr access on clk_sys and a slow clock far slower than clk_sys
//
// How it works
// (R1) With zero trim magnitude the 23-bit count steps by one on every slow clock cycle.
// (R2) On 23-bit overflow the upper byte loads the reload value and the lower bits wrap.
// (R3) Positive trim with nonzero magnitude steps the count by two on chosen slow cycles.
// (R4) Negative trim with nonzero magnitude holds the count on chosen slow cycles.
// (R5) Trim magnitude is bits 6..0 of the trim register, 0.477 ppm per step.
// (R6) Trim register bit 7 picks direction: 0 faster, 1 slower.
// (R7) Writing 1 to aux control bit 2 clears the count and reloads the upper byte.
// (R8) Interval code 00 ticks only on overflow of the full 23-bit count.
// (R9) Interval codes 01, 10, 11 tick every 32768, 16384, 8192 slow cycles.
// (R10) Each tick sets the tick flag in bit 0 of the interrupt flag register.
// (R11) The tick flag clears when the processor vectors to its service routine.
// (R12) Writing FEh to the interrupt flag register clears the tick flag.
// (R13) The count reads as low byte 7..0, mid bits 14..8 and upper byte 22..15.
// (R14) Software reading the count on the fast clock must filter for torn values.
// (R15) The tick flag reaches the processor once per tick while the slow clock runs far slower than clk_sys.
// (R16) Trim steps spread evenly, one per 2^21 slow cycles per magnitude step.
// (R17) The slow clock crosses into clk_sys through a synchroniser, each edge used once.
`timescale 1ns/1ps

`include "sctt_regs.svh"

module sctt_timer (
  input  logic                   clk_sys,
  input  logic                   resetn,
  input  logic                   slow_clk_in,
  input  sctt_pkg::sctt_sfr_req_t sfr_req,
  input  logic                   isr_ack,
  output logic [7:0]             sfr_rdata,
  output logic                   tick_flag
);
  import sctt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  option_q;
  logic [7:0]  reload_q;
  logic [7:0]  trim_q;
  logic [4:0]  aux_q;
  logic        flag_q;
  logic [22:0] cnt_q;
  logic [`SCTT_TRIM_ACC_W-1:0] acc_q;
  logic        slow_s1_q;
  logic        slow_s2_q;
  logic        slow_s3_q;
  logic [7:0]  rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // sfr decode

  wire wr_opt    = sfr_req.wr && (sfr_req.addr == `SCTT_ADDR_OPTION);
  wire wr_interrupt_flags = sfr_req.wr && (sfr_req.addr == `SCTT_ADDR_INTERRUPT_FLAGS);
  wire wr_reload = sfr_req.wr && (sfr_req.addr == `SCTT_ADDR_RELOAD);
  wire wr_trim   = sfr_req.wr && (sfr_req.addr == `SCTT_ADDR_TRIM);
  wire wr_aux    = sfr_req.wr && (sfr_req.addr == `SCTT_ADDR_AUX);

  // clear request is a write strobe only; the bit never stays set
  wire clr_req   = wr_aux && sfr_req.wdata[`SCTT_AUX_CLR_BIT]; // [R7]

  //////////////////////////////////////////////////////////////////////////////
  // slow clock edge

  // only s2 reads s1; the edge detector works on s2 and s3
  wire slow_edge = slow_s2_q && !slow_s3_q; // [R17]

  //////////////////////////////////////////////////////////////////////////////
  // trim

  wire [6:0] trim_mag  = trim_q[6:0]; // [R5]
  wire       trim_slow = trim_q[`SCTT_TRIM_SIGN_BIT]; // [R6]
  wire       trim_on   = (trim_mag != 7'h00);

  // carry of a 21-bit phase accumulator: mag carries per 2^21 slow cycles
  wire [`SCTT_TRIM_ACC_W:0] acc_sum = {1'b0, acc_q} + {15'h0000, trim_mag}; // [R16]
  wire adj_now = trim_on && acc_sum[`SCTT_TRIM_ACC_W]; // [R16]

  // step size: 1 normally, 2 or 0 on an adjust cycle
  wire [1:0] step_w = !adj_now ? 2'd1 : (trim_slow ? 2'd0 : 2'd2); // [R1] [R3] [R4]

  //////////////////////////////////////////////////////////////////////////////
  // count

  wire [23:0] sum_w  = {1'b0, cnt_q} + {22'h000000, step_w};
  wire        ovf_w  = sum_w[23];
  // a step of two across the top leaves a one in the low bits, kept as is
  wire [22:0] next_w = ovf_w ? {reload_q, sum_w[14:0]} : sum_w[22:0]; // [R2]

  //////////////////////////////////////////////////////////////////////////////
  // tick

  // cross_w[k]: this step crosses a multiple of 2^(15-k) slow counts
  logic [2:0] cross_w;
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_cross
      localparam int B = `SCTT_TICK_BIT_S32K - k;
      assign cross_w[k] = (sum_w[23:B] != {1'b0, cnt_q[22:B]}); // [R9]
    end
  endgenerate

  sctt_interval_t ivl_w;
  assign ivl_w = sctt_interval_t'(option_q[1:0]);

  logic ivl_hit;
  always_comb begin
    case (ivl_w)
      SCTT_IVL_OVF: ivl_hit = ovf_w; // [R8]
      SCTT_IVL_32K: ivl_hit = cross_w[0]; // [R9]
      SCTT_IVL_16K: ivl_hit = cross_w[1]; // [R9]
      SCTT_IVL_8K:  ivl_hit = cross_w[2]; // [R9]
      default:      ivl_hit = 1'b0;
    endcase
  end

  // a clear in the same cycle wins over the count step, so no tick then
  wire tick_evt = slow_edge && !clr_req && ivl_hit; // [R15]

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // mid register is 7 bits wide; bit 7 reads zero
  logic [7:0] rd_mux_w;
  always_comb begin
    case (sfr_req.addr)
      `SCTT_ADDR_OPTION:    rd_mux_w = option_q;
      `SCTT_ADDR_INTERRUPT_FLAGS:    rd_mux_w = {7'h00, flag_q};
      `SCTT_ADDR_CNT_UPPER: rd_mux_w = cnt_q[22:15]; // [R13]
      `SCTT_ADDR_CNT_LOW:   rd_mux_w = cnt_q[7:0]; // [R13]
      `SCTT_ADDR_CNT_MID:   rd_mux_w = {1'b0, cnt_q[14:8]}; // [R13]
      `SCTT_ADDR_RELOAD:    rd_mux_w = reload_q;
      `SCTT_ADDR_TRIM:      rd_mux_w = trim_q;
      `SCTT_ADDR_AUX:       rd_mux_w = {3'h0, aux_q};
      default:              rd_mux_w = `SCTT_UNMAPPED_READ;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag next value

  // hardware set wins over both clears in the same cycle
  wire flag_clr = isr_ack // [R11]
                || (wr_interrupt_flags && (sfr_req.wdata == `SCTT_INTERRUPT_FLAGS_CLR_VAL)); // [R12]
  wire flag_d   = tick_evt || (flag_q && !flag_clr); // [R10]

  //////////////////////////////////////////////////////////////////////////////
  // flip-flops

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end else begin
      slow_s1_q <= slow_clk_in; // [R17]
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      option_q <= `SCTT_RST_OPTION;
      reload_q <= `SCTT_RST_RELOAD;
      trim_q   <= `SCTT_RST_TRIM;
      aux_q    <= `SCTT_RST_AUX;
    end else begin
      if (wr_opt)    option_q <= sfr_req.wdata;
      if (wr_reload) reload_q <= sfr_req.wdata;
      if (wr_trim)   trim_q   <= sfr_req.wdata;
      if (wr_aux)    aux_q    <= sfr_req.wdata[4:0] & `SCTT_AUX_RW_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= `SCTT_RST_COUNT;
      acc_q <= '0;
    end else if (clr_req) begin
      cnt_q <= {reload_q, 15'h0000}; // [R7]
    end else if (slow_edge) begin
      cnt_q <= next_w;
      acc_q <= acc_sum[`SCTT_TRIM_ACC_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      flag_q <= flag_d;
      if (sfr_req.rd) rdata_q <= rd_mux_w; // [R13]
    end
  end

  // count read is live; a fast core may see bytes from two different counts
  assign sfr_rdata = rdata_q; // [R14]
  assign tick_flag = flag_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  AST_STEP_ONE: assert property ( // [R1]
    slow_edge && !clr_req && !trim_on && (cnt_q != 23'h7fffff)
    |=> cnt_q == $past(cnt_q) + 23'h000001
  ) else $error("count did not step by one");

  AST_OVF_RELOAD: assert property ( // [R2]
    slow_edge && !clr_req && !trim_on && (cnt_q == 23'h7fffff)
    |=> (cnt_q[22:15] == $past(reload_q)) && (cnt_q[14:0] == 15'h0000)
  ) else $error("overflow did not reload the upper byte");

  AST_POS_TRIM: assert property ( // [R3]
    slow_edge && !clr_req && adj_now && !trim_slow && (cnt_q[22:1] != 22'h3fffff)
    |=> cnt_q == $past(cnt_q) + 23'h000002
  ) else $error("positive trim did not step by two");

  AST_NEG_TRIM: assert property ( // [R4]
    slow_edge && !clr_req && adj_now && trim_slow
    |=> $stable(cnt_q)
  ) else $error("negative trim did not hold the count");

  AST_NO_ADJ_ZERO: assert property ( // [R5]
    (trim_mag == 7'h00) |-> !adj_now
  ) else $error("adjust cycle with zero magnitude");

  AST_CLEAR: assert property ( // [R7]
    clr_req
    |=> (cnt_q[14:0] == 15'h0000) && (cnt_q[22:15] == $past(reload_q))
  ) else $error("clear request did not clear and reload");

  AST_TICK_OVF: assert property ( // [R8]
    tick_evt && (ivl_w == SCTT_IVL_OVF) |-> ovf_w
  ) else $error("overflow interval ticked without overflow");

  AST_TICK_8K: assert property ( // [R9]
    tick_evt && (ivl_w == SCTT_IVL_8K) && !ovf_w |=> (cnt_q[12:0] < 13'h0002)
  ) else $error("8192 interval tick off its boundary");

  AST_FLAG_SET: assert property ( // [R10]
    tick_evt |=> flag_q
  ) else $error("tick did not set the flag");

  AST_ISR_CLR: assert property ( // [R11]
    flag_q && isr_ack && !tick_evt |=> !flag_q
  ) else $error("vectoring did not clear the flag");

  AST_FE_CLR: assert property ( // [R12]
    wr_interrupt_flags && (sfr_req.wdata == 8'hfe) && !tick_evt |=> !flag_q
  ) else $error("writing fe did not clear the flag");

  AST_RD_MID: assert property ( // [R13]
    sfr_req.rd && (sfr_req.addr == 8'hb5)
    |=> sfr_rdata == {1'b0, $past(cnt_q[14:8])}
  ) else $error("mid count read wrong");

  AST_ONE_TICK: assert property ( // [R15]
    tick_evt |=> !tick_evt
  ) else $error("tick event lasted more than one cycle");

  AST_EDGE_ONCE: assert property ( // [R17]
    slow_edge |=> !slow_edge [*2]
  ) else $error("slow clock edge used twice");

  // count only moves on a slow edge or a clear
  AST_COUNT_HOLD: assert property ( // [R1]
    !slow_edge && !clr_req |=> $stable(cnt_q)
  ) else $error("count moved without a slow edge");

  AST_TICK_32K: assert property ( // [R9]
    tick_evt && (ivl_w == SCTT_IVL_32K) && !ovf_w |=> (cnt_q[14:0] < 15'h0002)
  ) else $error("32768 interval tick off its boundary");

  AST_TICK_16K: assert property ( // [R9]
    tick_evt && (ivl_w == SCTT_IVL_16K) && !ovf_w |=> (cnt_q[13:0] < 14'h0002)
  ) else $error("16384 interval tick off its boundary");

  AST_CLR_NO_TICK: assert property ( // [R15]
    clr_req |-> !tick_evt
  ) else $error("tick raised in a clear cycle");

  // the clear must not disturb the trim phase, or trim would drift
  AST_ACC_ON_CLR: assert property ( // [R16]
    clr_req |=> $stable(acc_q)
  ) else $error("clear disturbed the trim accumulator");

  AST_FLAG_HOLD: assert property ( // [R10]
    !tick_evt && !flag_clr |=> $stable(flag_q)
  ) else $error("tick flag changed without a cause");

  AST_RDATA_HOLD: assert property ( // [R13]
    !sfr_req.rd |=> $stable(sfr_rdata)
  ) else $error("read data changed without a read");

endmodule

// File: rtl/sctt_regs.svh
// register map, field positions, reset values and counts of the slow tick timer
// assumes an 8-bit special function register space addressed by 8-bit offsets
`ifndef SCTT_REGS_SVH
`define SCTT_REGS_SVH

// offsets
`define SCTT_ADDR_OPTION     8'h94
`define SCTT_ADDR_INTERRUPT_FLAGS     8'h95
`define SCTT_ADDR_CNT_UPPER  8'hb3
`define SCTT_ADDR_CNT_LOW    8'hb4
`define SCTT_ADDR_CNT_MID    8'hb5
`define SCTT_ADDR_RELOAD     8'hb6
`define SCTT_ADDR_TRIM       8'hb7
`define SCTT_ADDR_AUX        8'hf8

// reset values
`define SCTT_RST_OPTION      8'hc1
`define SCTT_RST_RELOAD      8'h00
`define SCTT_RST_TRIM        8'h00
`define SCTT_RST_AUX         5'h00
`define SCTT_RST_COUNT       23'h000000

// field positions and codes
`define SCTT_TRIM_SIGN_BIT   7
`define SCTT_AUX_CLR_BIT     2
`define SCTT_AUX_RW_MASK     5'h1b
`define SCTT_FLAG_BIT        0
`define SCTT_INTERRUPT_FLAGS_CLR_VAL  8'hfe
`define SCTT_UNMAPPED_READ   8'h00

// timing: bit whose carry marks 32768 slow cycles; 16384 and 8192 sit below it
`define SCTT_TICK_BIT_S32K   15
`define SCTT_TRIM_ACC_W      21

`endif

// File: rtl/sctt_pkg.sv
// types shared by the slow tick timer
// assumes the constants of sctt_regs.svh for offsets and fields
package sctt_pkg;

  // one cycle special function register access from the processor core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sctt_sfr_req_t;

  // tick interval select codes, in field order
  typedef enum logic [1:0] {
    SCTT_IVL_OVF,
    SCTT_IVL_32K,
    SCTT_IVL_16K,
    SCTT_IVL_8K
  } sctt_interval_t;

endpackage

// File: test/sctt_timer_tb.sv
// self-checking bench for the slow tick timer: registers, count, ticks
// assumes sctt_pkg compiled first and sctt_regs.svh on the include path
`timescale 1ns/1ps

`include "sctt_regs.svh"

module test_slow_clock_trimmed_tick_timer;
  import sctt_pkg::*;

  logic          clk_sys;
  logic          resetn;
  logic          slow_clk_in;
  sctt_sfr_req_t sfr_req;
  logic          isr_ack;
  logic [7:0]    sfr_rdata;
  logic          tick_flag;
  int            mismatches;
  int            checks;
  logic [31:0]   seed;
  logic [7:0]    rld;
  logic [7:0]    v;
  logic [7:0]    got;
  logic [22:0]   cnt;
  int            n;

  sctt_timer i_sctt_timer (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .slow_clk_in (slow_clk_in),
    .sfr_req     (sfr_req),
    .isr_ack     (isr_ack),
    .sfr_rdata   (sfr_rdata),
    .tick_flag   (tick_flag)
  );

  always #25 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // count right after a clear with reload r and n untrimmed slow cycles
  function automatic logic [22:0] exp_count(input logic [7:0] r, input int n);
    return {r, 15'h0000} + 23'(n);
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req.addr  = a;
    sfr_req.wdata = d;
    sfr_req.wr    = 1'b1;
    @(posedge clk_sys);
    #1 sfr_req.wr = 1'b0;
  endtask

  // strobe taken at one edge; data is sampled one edge later, where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req.addr = a;
    sfr_req.rd   = 1'b1;
    @(posedge clk_sys);
    #1 sfr_req.rd = 1'b0;
    @(posedge clk_sys);
    #1 d = sfr_rdata;
  endtask

  // pin held 3 clocks per phase, longer than the synchroniser and edge detector need
  task automatic slow(input int k);
    repeat (k) begin
      slow_clk_in = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 slow_clk_in = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (101000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    slow_clk_in = 1'b0;
    sfr_req = '0;
    isr_ack = 1'b0;
    mismatches = 0;
    checks = 0;
    seed = 32'h5eb94821;
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1'b1;
    rd(`SCTT_ADDR_OPTION, got); chk(got, 8'hc1);
    rd(`SCTT_ADDR_RELOAD, got); chk(got, 8'h00);
    rd(`SCTT_ADDR_TRIM, got); chk(got, 8'h00);
    rd(`SCTT_ADDR_AUX, got); chk(got, 8'h00);
    rd(`SCTT_ADDR_INTERRUPT_FLAGS, got); chk(got, 8'h00);
    rd(8'hb8, got); chk(got, 8'h00);
    rld = rnd();
    wr(`SCTT_ADDR_RELOAD, rld);
    rd(`SCTT_ADDR_RELOAD, got); chk(got, rld);
    v = rnd();
    wr(`SCTT_ADDR_TRIM, v);
    rd(`SCTT_ADDR_TRIM, got); chk(got, v);
    // trim back to zero so that every later count is exact
    wr(`SCTT_ADDR_TRIM, 8'h00);
    // let one edge pass so that the write strobe is not lowered and raised at once
    @(posedge clk_sys);
    #1;
    v = {rnd() >> 2, 2'b11};
    wr(`SCTT_ADDR_OPTION, v);
    rd(`SCTT_ADDR_OPTION, got); chk(got, v);
    v = rnd() | 32'h4;
    wr(`SCTT_ADDR_AUX, v);
    rd(`SCTT_ADDR_AUX, got); chk(got, v & 8'h1b);
    n = 1 + (rnd() % 40);
    slow(n);
    cnt = exp_count(rld, n);
    // slow pin is idle here, so the count bytes cannot tear between reads
    rd(`SCTT_ADDR_CNT_LOW, got); chk(got, cnt[7:0]);
    rd(`SCTT_ADDR_CNT_MID, got); chk(got, {1'b0, cnt[14:8]});
    wr(`SCTT_ADDR_CNT_UPPER, rnd());
    rd(`SCTT_ADDR_CNT_UPPER, got); chk(got, cnt[22:15]);
    // fresh clear: 8192 slow cycles to the first tick at code 11
    wr(`SCTT_ADDR_AUX, 8'h04);
    slow(8191);
    chk(tick_flag, 1'b0);
    slow(1);
    chk(tick_flag, 1'b1);
    v = rnd();
    if (v == 8'hfe) v = 8'h00;
    wr(`SCTT_ADDR_INTERRUPT_FLAGS, v);
    chk(tick_flag, 1'b1);
    isr_ack = 1'b1;
    @(posedge clk_sys);
    #1 isr_ack = 1'b0;
    @(posedge clk_sys);
    #1 chk(tick_flag, 1'b0);
    // code 10: count 16383 is no tick, 16384 is
    wr(`SCTT_ADDR_OPTION, 8'hc2);
    slow(8191);
    chk(tick_flag, 1'b0);
    slow(1);
    chk(tick_flag, 1'b1);
    wr(`SCTT_ADDR_INTERRUPT_FLAGS, 8'hfe);
    @(posedge clk_sys);
    #1 chk(tick_flag, 1'b0);
    summarize();
  end
endmodule
